//--- rtl/tw_consts.svh
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH

`define TW_DAT_OFS     8'h9A
`define TW_ADD_OFS     8'h9B
`define TW_CON_OFS     8'hE8
`define TW_DAT_RST     8'h00
`define TW_ADD_RST     8'h55
`define TW_CON_RST     8'h00
`define TW_BIT_DO      7
`define TW_BIT_OE      6
`define TW_BIT_CO      5
`define TW_BIT_DI      4
`define TW_BIT_ROLE    3
`define TW_BIT_SRST    2
`define TW_BIT_DIR     1
`define TW_BIT_FLAG    0
`define TW_CLK_NS      10
`define TW_SPIKE_NS    50
`define TW_FILT_CYC    ((`TW_SPIKE_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)
`endif

//--- rtl/tw_pkg.sv
package tw_pkg;
   typedef struct packed {
      logic serial_data_pin;
      logic serial_clock_pin;
   } pad_t;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_AACK, S_HOLD, S_RX, S_DACK, S_TX, S_MACK,
      S_HALT
   } slave_state_t;
endpackage

//--- rtl/tw_line_filter.sv
`include "tw_consts.svh"
module tw_line_filter (
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   // Raw pin and clean level
   input  wire logic line_i,
   output logic      line_o
);
   localparam int FILT_CYC = `TW_FILT_CYC;

   logic       sync1_r;
   logic       sync2_r;
   logic [3:0] cnt_r;
   logic       differs;

   assign differs = sync2_r != line_o;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end else begin
         sync1_r <= line_i;
         sync2_r <= sync1_r;
      end
   end

   // New level must hold for the full spike time
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt_r  <= 4'h0;
         line_o <= 1'b1;
      end else if (!differs) begin
         cnt_r <= 4'h0;
      end else if (cnt_r == 4'(FILT_CYC - 1)) begin
         cnt_r  <= 4'h0;
         line_o <= sync2_r;
      end else begin
         cnt_r <= cnt_r + 4'h1;
      end
   end

   glitch_reject_a: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $changed(line_o) |-> $past(cnt_r) == 4'(FILT_CYC - 1))
      else $error("line changed before spike time elapsed");
endmodule

//--- rtl/tw_serial_port.sv
`include "tw_consts.svh"
module tw_serial_port (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // Special function register access
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic [7:0]  sfr_wdata_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   output logic      [7:0]  sfr_rdata_o,
   // Pin sharing with SPI
   input  wire logic        spi_port_select_i,
   // Shared pins
   input  wire tw_pkg::pad_t pad_i,
   output tw_pkg::pad_t      pad_o,
   output tw_pkg::pad_t      pad_oe_o,
   // Interrupt request
   output logic              slave_irq_o
);
   import tw_pkg::*;
   logic         sw_data_out_r;
   logic         sw_data_out_enable_r;
   logic         sw_clock_out_r;
   logic         sw_data_in_r;
   logic         role_select_r;
   logic         slave_reset_r;
   logic         slave_direction_r;
   logic         slave_byte_flag_r;
   logic [7:0]   own_slave_address_r;
   logic [7:0]   serial_data_byte_r;
   logic [7:0]   shift_r;
   logic [7:0]   shift_nxt;
   logic [3:0]   cnt_r;
   logic [3:0]   cnt_nxt;
   logic         acc_done_r;
   slave_state_t state_r;
   slave_state_t state_nxt;
   pad_t         filt;
   pad_t         prev_r;
   logic [1:0]   filt_bits;
   logic         flag_set;
   logic         rx_load;
   logic         addr_hit;
   assign filt     = filt_bits;
   for (genvar i = 0; i < 2; i++) begin : g_filt
      tw_line_filter u_filt (
         .sys_clk_i (sys_clk_i),
         .rst_i     (rst_i),
         .line_i    (pad_i[i]),
         .line_o    (filt_bits[i])
      );
   end
   // Decode and bus events
   wire con_sel   = sfr_addr_i == `TW_CON_OFS;
   wire add_sel   = sfr_addr_i == `TW_ADD_OFS;
   wire dat_sel   = sfr_addr_i == `TW_DAT_OFS;
   wire dat_acc   = dat_sel && (sfr_wr_i || sfr_rd_i);
   wire master_on = !spi_port_select_i && role_select_r;
   wire slave_on  = !spi_port_select_i && !role_select_r
                    && !slave_reset_r;
   wire scl_rise  = filt.serial_clock_pin && !prev_r.serial_clock_pin;
   wire scl_fall  = !filt.serial_clock_pin && prev_r.serial_clock_pin;
   wire scl_high  = filt.serial_clock_pin && prev_r.serial_clock_pin;
   wire start_det = scl_high && prev_r.serial_data_pin
                    && !filt.serial_data_pin;
   wire stop_det  = scl_high && !prev_r.serial_data_pin
                    && filt.serial_data_pin;
   wire sda_in    = filt.serial_data_pin;
   wire [7:0] con_val = {sw_data_out_r, sw_data_out_enable_r,
                         sw_clock_out_r, sw_data_in_r, role_select_r,
                         slave_reset_r, slave_direction_r,
                         slave_byte_flag_r};
   wire [7:0] rd_nxt = con_sel ? con_val :
                       add_sel ? own_slave_address_r :
                       dat_sel ? serial_data_byte_r : 8'h00;
   wire sda_low = (state_r == S_AACK) || (state_r == S_DACK)
                  || ((state_r == S_TX) && !shift_r[7]);
   wire scl_low = (state_r == S_HOLD) && slave_byte_flag_r;
   always_comb begin
      state_nxt = state_r;
      shift_nxt = shift_r;
      cnt_nxt   = cnt_r;
      flag_set  = 1'b0;
      rx_load   = 1'b0;
      addr_hit  = 1'b0;
      if (!slave_on) begin
         state_nxt = S_IDLE;
         cnt_nxt   = 4'h0;
      end else if (dat_acc && acc_done_r) begin
         state_nxt = S_HALT;
      end else if (state_r == S_HALT) begin
         state_nxt = S_HALT;
      end else if (stop_det) begin
         state_nxt = S_IDLE;
      end else if (start_det) begin
         state_nxt = S_ADDR;
         cnt_nxt   = 4'h0;
      end else begin
         case (state_r)
            S_ADDR, S_RX: begin
               if (scl_rise) begin
                  shift_nxt = {shift_r[6:0], sda_in};
                  cnt_nxt   = cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == 4'h8) begin
                  cnt_nxt = 4'h0;
                  if (state_r == S_RX) begin
                     rx_load   = 1'b1;
                     flag_set  = 1'b1;
                     state_nxt = S_DACK;
                  end else if (shift_r[7:1] ==
                               own_slave_address_r[6:0]) begin
                     addr_hit  = 1'b1;
                     rx_load   = 1'b1;
                     flag_set  = 1'b1;
                     state_nxt = S_AACK;
                  end else begin
                     state_nxt = S_IDLE;
                  end
               end
            end
            S_AACK, S_DACK: begin
               if (scl_fall) begin
                  state_nxt = S_HOLD;
               end
            end
            S_HOLD: begin
               if (!slave_byte_flag_r) begin
                  state_nxt = slave_direction_r ? S_TX : S_RX;
                  shift_nxt = serial_data_byte_r;
                  cnt_nxt   = 4'h0;
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  shift_nxt = {shift_r[6:0], 1'b1};
                  cnt_nxt   = cnt_r + 4'h1;
                  if (cnt_r == 4'h7) begin
                     state_nxt = S_MACK;
                     cnt_nxt   = 4'h0;
                  end
               end
            end
            S_MACK: begin
               if (scl_rise && sda_in) begin
                  state_nxt = S_IDLE;
               end else if (scl_rise) begin
                  flag_set = 1'b1;
                  cnt_nxt  = 4'h1;
               end else if (scl_fall && cnt_r == 4'h1) begin
                  state_nxt = S_HOLD;
               end
            end
            default: state_nxt = S_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_r <= S_IDLE;
         shift_r <= 8'h00;
         cnt_r   <= 4'h0;
         prev_r  <= 2'h3;
      end else begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         cnt_r   <= cnt_nxt;
         prev_r  <= filt;
      end
   end
   // Registers seen by software
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         {sw_data_out_r, sw_data_out_enable_r, sw_clock_out_r} <= 3'h0;
         role_select_r       <= 1'(`TW_CON_RST >> `TW_BIT_ROLE);
         slave_reset_r       <= 1'b0;
         own_slave_address_r <= `TW_ADD_RST;
      end else if (sfr_wr_i && con_sel) begin
         sw_data_out_r        <= sfr_wdata_i[`TW_BIT_DO];
         sw_data_out_enable_r <= sfr_wdata_i[`TW_BIT_OE];
         sw_clock_out_r       <= sfr_wdata_i[`TW_BIT_CO];
         role_select_r        <= sfr_wdata_i[`TW_BIT_ROLE];
         slave_reset_r        <= sfr_wdata_i[`TW_BIT_SRST];
      end else if (sfr_wr_i && add_sel) begin
         own_slave_address_r <= sfr_wdata_i;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         serial_data_byte_r <= `TW_DAT_RST;
      end else if (rx_load) begin
         serial_data_byte_r <= shift_r;
      end else if (sfr_wr_i && dat_sel) begin
         serial_data_byte_r <= sfr_wdata_i;
      end
   end
   // Flags: a set in the clearing cycle wins, except acc_done_r, where the clear wins
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         slave_byte_flag_r <= 1'b0;
         slave_direction_r <= 1'b0;
         acc_done_r        <= 1'b0;
         sw_data_in_r      <= 1'b0;
         sfr_rdata_o       <= 8'h00;
      end else begin
         if (flag_set)
            slave_byte_flag_r <= 1'b1;
         else if (dat_acc || !slave_on)
            slave_byte_flag_r <= 1'b0;
         if (addr_hit)
            slave_direction_r <= shift_r[0];
         else if (!slave_on)
            slave_direction_r <= 1'b0;
         if (flag_set || !slave_on)
            acc_done_r <= 1'b0;
         else if (dat_acc)
            acc_done_r <= 1'b1;
         if (master_on && !sw_data_out_enable_r && scl_rise)
            sw_data_in_r <= sda_in;
         if (sfr_rd_i)
            sfr_rdata_o <= rd_nxt;
      end
   end
   // Pin drive
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pad_o       <= 2'h0;
         pad_oe_o    <= 2'h0;
         slave_irq_o <= 1'b0;
      end else begin
         slave_irq_o <= slave_byte_flag_r;
         if (master_on) begin
            pad_o    <= {sw_data_out_r, sw_clock_out_r};
            pad_oe_o <= {sw_data_out_enable_r, 1'b1};
         end else if (slave_on) begin
            pad_o    <= 2'h0;
            pad_oe_o <= {sda_low, scl_low};
         end else begin
            pad_o    <= 2'h0;
            pad_oe_o <= 2'h0;
         end
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence second_access_s;
      slave_on && dat_acc && acc_done_r;
   endsequence
   spi_release_a: assert property (
      spi_port_select_i |=> pad_oe_o == 2'h0)
      else $error("pins driven while SPI owns them");
   sda_drive_a: assert property (
      master_on && sw_data_out_enable_r |=> pad_oe_o.serial_data_pin
      && pad_o.serial_data_pin == $past(sw_data_out_r))
      else $error("data pin not driven from data out bit");
   sda_input_a: assert property (
      master_on && !sw_data_out_enable_r |=> !pad_oe_o.serial_data_pin)
      else $error("data pin driven while enable clear");
   scl_drive_a: assert property (
      master_on |=> pad_oe_o.serial_clock_pin
      && pad_o.serial_clock_pin == $past(sw_clock_out_r))
      else $error("clock pin does not follow clock out bit");
   di_capture_a: assert property (
      master_on && !sw_data_out_enable_r && scl_rise
      |=> sw_data_in_r == $past(sda_in))
      else $error("data in bit missed rising clock sample");
   flag_clear_a: assert property (
      dat_acc && !flag_set |=> !slave_byte_flag_r)
      else $error("data access did not clear byte flag");
   reset_idle_a: assert property (
      slave_reset_r && !role_select_r && !(sfr_wr_i && con_sel)
      |=> state_r == S_IDLE ##1 !pad_oe_o.serial_clock_pin)
      else $error("slave active while reset bit held");
   stretch_hold_a: assert property (
      slave_on && scl_low |=> pad_oe_o.serial_clock_pin
      && !pad_o.serial_clock_pin)
      else $error("clock not held low while flag pending");
   halt_on_twice_a: assert property (
      second_access_s |=> state_r == S_HALT)
      else $error("second data access did not halt");
   stop_idle_a: assert property (
      slave_on && stop_det && state_r != S_HALT && !dat_acc
      |=> state_r == S_IDLE)
      else $error("stop did not return slave to idle");
   addr_miss_a: assert property (
      state_r == S_ADDR && slave_on && scl_fall && cnt_r == 4'h8
      && !start_det && !stop_det && !(dat_acc && acc_done_r)
      && shift_r[7:1] != own_slave_address_r[6:0]
      |=> state_r == S_IDLE && !$rose(slave_byte_flag_r))
      else $error("slave answered a foreign address");
   dir_latch_a: assert property (
      addr_hit |=> slave_direction_r == $past(shift_r[0])
      && slave_byte_flag_r)
      else $error("direction not taken from address byte");
   addr_reset_a: assert property (
      @(posedge sys_clk_i) disable iff (1'b0)
      rst_i |=> own_slave_address_r == `TW_ADD_RST)
      else $error("own address reset value wrong");
endmodule

//--- tb/tw_bus_master.sv
module tw_bus_master (
   input  wire logic         sys_clk_i,
   input  wire tw_pkg::pad_t bus_i,
   output logic              scl_low_o,
   output logic              sda_low_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int stalls = 0;

   // Open drain: high output pulls the wire low
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // Restarts the high count while the slave stretches the clock
   task automatic wait_high();
      int hi;
      int n;
      hi = 0;
      n = 0;
      while (hi < 6 && n < 4000) begin
         @(posedge sys_clk_i);
         hi = (bus_i.serial_clock_pin === 1'b1) ? hi + 1 : 0;
         n++;
      end
      if (hi < 6) begin
         stalls++;
      end
   endtask

   // One 160 ns bit: 100 ns low, 60 ns high, sample at end of high
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      sda_low_o <= !b;
      tick(8);
      scl_low_o <= 1'b0;
      wait_high();
      r = bus_i.serial_data_pin;
      scl_low_o <= 1'b1;
   endtask

   task automatic start();
      sda_low_o <= 1'b1;
      tick(8);
      scl_low_o <= 1'b1;
   endtask

   task automatic stop();
      tick(2);
      sda_low_o <= 1'b1;
      tick(8);
      scl_low_o <= 1'b0;
      wait_high();
      sda_low_o <= 1'b0;
      tick(16);
   endtask

   // Eight bits MSB first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic ack_in,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack);
   endtask

   task automatic pull_data(input logic low);
      @(posedge sys_clk_i);
      sda_low_o <= low;
   endtask
endmodule

//--- tb/test_tw_serial_port.sv
`define CHK(g, e) \
   begin \
      comparisons++; \
      if ((g) !== (e)) begin \
         fails++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
      end \
   end

module test_tw_serial_port;
   timeunit 1ns;
   timeprecision 1ps;
   import tw_pkg::*;

   logic       sys_clk_i = 1'b0;
   logic       rst_i;
   logic [7:0] sfr_addr_i;
   logic [7:0] sfr_wdata_i;
   logic       sfr_wr_i;
   logic       sfr_rd_i;
   logic [7:0] sfr_rdata_o;
   logic       spi_port_select_i;
   pad_t       pad_o;
   pad_t       pad_oe_o;
   pad_t       bus_w;
   logic       slave_irq_o;
   logic       m_scl_low;
   logic       m_sda_low;
   logic [7:0] d;
   logic [7:0] q;
   logic       ack;
   int         fails = 0;
   int         comparisons = 0;

   // Wire level from every party's drive
   assign bus_w.serial_clock_pin = (pad_oe_o.serial_clock_pin ?
      pad_o.serial_clock_pin : 1'b1) & !m_scl_low;
   assign bus_w.serial_data_pin = (pad_oe_o.serial_data_pin ?
      pad_o.serial_data_pin : 1'b1) & !m_sda_low;

   always #5 sys_clk_i = ~sys_clk_i;

   tw_serial_port u_dut (
      .sys_clk_i        (sys_clk_i),
      .rst_i            (rst_i),
      .sfr_addr_i       (sfr_addr_i),
      .sfr_wdata_i      (sfr_wdata_i),
      .sfr_wr_i         (sfr_wr_i),
      .sfr_rd_i         (sfr_rd_i),
      .sfr_rdata_o      (sfr_rdata_o),
      .spi_port_select_i(spi_port_select_i),
      .pad_i            (bus_w),
      .pad_o            (pad_o),
      .pad_oe_o         (pad_oe_o),
      .slave_irq_o      (slave_irq_o)
   );

   tw_bus_master u_master (
      .sys_clk_i(sys_clk_i),
      .bus_i    (bus_w),
      .scl_low_o(m_scl_low),
      .sda_low_o(m_sda_low)
   );

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= v;
      sfr_wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      sfr_wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk_i);
      sfr_addr_i <= a;
      sfr_rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      sfr_rd_i   <= 1'b0;
      @(negedge sys_clk_i);
      v = sfr_rdata_o;
   endtask

   task automatic results();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk_i);
      fails++;
      results();
   end

   initial begin
      rst_i = 1'b1;
      sfr_addr_i = 8'h00;
      sfr_wdata_i = 8'h00;
      sfr_wr_i = 1'b0;
      sfr_rd_i = 1'b0;
      spi_port_select_i = 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      settle(10);
      rd(8'hE8, d); `CHK(d, 8'h00)
      rd(8'h9B, d); `CHK(d, 8'h55)
      rd(8'h9A, d); `CHK(d, 8'h00)
      rd(8'h9C, d); `CHK(d, 8'h00)
      // Status bits are read-only, reset bit sticks
      wr(8'hE8, 8'h17);
      rd(8'hE8, d); `CHK(d, 8'h04)
      u_master.start();
      u_master.xfer(8'hAA, 1'b1, q, ack); `CHK(ack, 1'b1)
      `CHK(pad_oe_o, 2'h0)
      u_master.stop();
      wr(8'hE8, 8'h00);
      wr(8'h9B, 8'h3A);
      rd(8'h9B, d); `CHK(d, 8'h3A)
      // Old address no longer answered
      u_master.start();
      u_master.xfer(8'hAA, 1'b1, q, ack); `CHK(ack, 1'b1)
      rd(8'hE8, d); `CHK(d, 8'h00)
      u_master.stop();
      // Write transfer with clock stretch
      u_master.start();
      u_master.xfer(8'h74, 1'b1, q, ack); `CHK(ack, 1'b0)
      settle(20);
      `CHK(pad_oe_o.serial_clock_pin, 1'b1)
      `CHK(slave_irq_o, 1'b1)
      rd(8'hE8, d); `CHK(d, 8'h01)
      rd(8'h9A, d); `CHK(d, 8'h74)
      settle(4);
      `CHK(slave_irq_o, 1'b0)
      `CHK(pad_oe_o.serial_clock_pin, 1'b0)
      rd(8'hE8, d); `CHK(d, 8'h00)
      u_master.xfer(8'h3C, 1'b1, q, ack); `CHK(ack, 1'b0)
      settle(20);
      rd(8'hE8, d); `CHK(d, 8'h01)
      rd(8'h9A, d); `CHK(d, 8'h3C)
      u_master.stop();
      // Read transfer, ACK then NACK
      u_master.start();
      u_master.xfer(8'h75, 1'b1, q, ack); `CHK(ack, 1'b0)
      settle(20);
      rd(8'hE8, d); `CHK(d, 8'h03)
      wr(8'h9A, 8'hC5);
      u_master.xfer(8'hFF, 1'b0, q, ack); `CHK(q, 8'hC5)
      settle(20);
      rd(8'hE8, d); `CHK(d, 8'h03)
      wr(8'h9A, 8'h5A);
      u_master.xfer(8'hFF, 1'b1, q, ack); `CHK(q, 8'h5A)
      settle(20);
      rd(8'hE8, d); `CHK(d[0], 1'b0)
      `CHK(pad_oe_o, 2'h0)
      u_master.stop();
      // Second data access halts until reset bit cycles
      u_master.start();
      u_master.xfer(8'h74, 1'b1, q, ack);
      settle(20);
      rd(8'h9A, d);
      rd(8'h9A, d);
      settle(10);
      `CHK(pad_oe_o, 2'h0)
      u_master.xfer(8'h11, 1'b1, q, ack); `CHK(ack, 1'b1)
      u_master.stop();
      wr(8'hE8, 8'h04);
      wr(8'hE8, 8'h00);
      u_master.start();
      u_master.xfer(8'h74, 1'b1, q, ack); `CHK(ack, 1'b0)
      settle(20);
      rd(8'h9A, d);
      u_master.stop();
      // Software master: clock driven, data released while enable clear
      wr(8'hE8, 8'h08);
      settle(20);
      `CHK(pad_oe_o, 2'h1)
      `CHK(pad_o.serial_clock_pin, 1'b0)
      u_master.pull_data(1'b1);
      wr(8'hE8, 8'h28);
      settle(20);
      rd(8'hE8, d); `CHK(d, 8'h28)
      u_master.pull_data(1'b0);
      wr(8'hE8, 8'h08);
      settle(20);
      wr(8'hE8, 8'h28);
      settle(20);
      rd(8'hE8, d); `CHK(d, 8'h38)
      wr(8'hE8, 8'hC8);
      settle(4);
      `CHK(pad_oe_o, 2'h3)
      `CHK(pad_o, 2'h2)
      wr(8'hE8, 8'h68);
      settle(4);
      `CHK(pad_o, 2'h1)
      settle(20);
      rd(8'hE8, d); `CHK(d, 8'h78)
      spi_port_select_i <= 1'b1;
      settle(4);
      `CHK(pad_oe_o, 2'h0)
      spi_port_select_i <= 1'b0;
      wr(8'hE8, 8'hE0);
      settle(4);
      `CHK(pad_oe_o, 2'h0)
      `CHK(pad_o, 2'h0)
      `CHK(u_master.stalls, 0)
      results();
   end
endmodule
